// File: hcsp_defs.svh
// constants of the hub configuration serial port
`ifndef HCSP_DEFS_SVH
`define HCSP_DEFS_SVH
`define HCSP_CLK_HZ 40000000
`define HCSP_SCL_HZ 100000
`define HCSP_QTR_CYC (`HCSP_CLK_HZ / `HCSP_SCL_HZ / 4)
`define HCSP_TOUT_MS 25
`define HCSP_TOUT_CYC (`HCSP_CLK_HZ / 1000 * `HCSP_TOUT_MS)
`define HCSP_EE_ADDR 7'h50
`define HCSP_SMB_ADDR 7'h2C
`define HCSP_GCALL 7'h00
`define HCSP_REG_STAT 8'hFF
`define HCSP_LAST_REG 8'hFE
`define HCSP_MAX_CNT 8'h20
`define HCSP_BIT_PDN 2
`define HCSP_BIT_RST 1
`define HCSP_BIT_ATT 0
`define HCSP_STAT_MASK 8'h07
`define HCSP_MEM_RST 8'h00
`define HCSP_EE_LEN 9'h0FF
`endif

// File: hcsp_pkg.sv
// types of the hub configuration serial port
package hcsp_pkg;
    // two-wire drive pair: scl and sda output enables
    typedef struct packed {
        logic scl_oe;
        logic sda_oe;
    } hcsp_drv_t;
    // register write strobe
    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] data;
    } hcsp_wr_t;
endpackage

// File: hcsp_ee_master.sv
// eeprom sequential-read master
`timescale 1ns/100ps
`include "hcsp_defs.svh"
module hcsp_ee_master (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic i_sda,
    output hcsp_pkg::hcsp_drv_t o_drv,
    output hcsp_pkg::hcsp_wr_t o_wr,
    output logic o_done
);
    typedef enum logic [2:0] {
        HCSP_E_IDLE = 3'h0,
        HCSP_E_START = 3'h1,
        HCSP_E_BYTE = 3'h2,
        HCSP_E_STOP = 3'h3,
        HCSP_E_DONE = 3'h4
    } hcsp_e_st_t;
    hcsp_e_st_t st; // sequence state
    logic [11:0] qcnt; // quarter-bit timer
    logic [1:0] ph; // quarter phase
    logic [3:0] bitn; // bit within byte, 8 = ack
    logic [1:0] step; // 0 wr addr, 1 offset, 2 rd addr, 3 data
    logic [8:0] idx; // bytes read so far
    logic [7:0] sh; // shift register
    logic [7:0] tx; // byte to send
    wire tick = (qcnt == 12'(`HCSP_QTR_CYC - 1));
    wire is_rd = (step == 2'h3);
    wire last = (idx == `HCSP_EE_LEN);
    // outgoing bytes: write address, offset 0, read address
    assign tx = (step == 2'h0) ? {`HCSP_EE_ADDR, 1'b0} :
                (step == 2'h1) ? 8'h00 : {`HCSP_EE_ADDR, 1'b1};
    // quarter timer
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) qcnt <= 12'h000;
        else qcnt <= tick ? 12'h000 : qcnt + 12'h001;
    end
    // master sequencing, open-drain only, sequential read
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= HCSP_E_IDLE;
            ph <= 2'h0;
            bitn <= 4'h0;
            step <= 2'h0;
            idx <= 9'h000;
            sh <= 8'h00;
            o_drv <= '0;
            o_wr <= '0;
            o_done <= 1'b0;
        end else begin
            o_wr.we <= 1'b0;
            if (tick) begin
                ph <= ph + 2'h1;
                case (st)
                    HCSP_E_IDLE: begin
                        if (i_start) st <= HCSP_E_START;
                        ph <= 2'h0;
                    end
                    HCSP_E_START: begin
                        // sda falls while scl high, then scl low
                        if (ph == 2'h1) o_drv.sda_oe <= 1'b1;
                        if (ph == 2'h3) begin
                            o_drv.scl_oe <= 1'b1;
                            st <= HCSP_E_BYTE;
                            bitn <= 4'h0;
                        end
                    end
                    HCSP_E_BYTE: begin
                        case (ph)
                            2'h0: begin
                                // set data while clock low
                                if (bitn == 4'h8)
                                    o_drv.sda_oe <= is_rd & ~last;
                                else if (is_rd)
                                    o_drv.sda_oe <= 1'b0;
                                else
                                    o_drv.sda_oe <= ~tx[3'(7 - bitn)];
                            end
                            2'h1: o_drv.scl_oe <= 1'b0;
                            2'h2: if (bitn != 4'h8) sh <= {sh[6:0], i_sda};
                            default: begin
                                o_drv.scl_oe <= 1'b1;
                                bitn <= bitn + 4'h1;
                                if (bitn == 4'h8) begin
                                    bitn <= 4'h0;
                                    if (is_rd) begin
                                        o_wr <= '{1'b1, idx[7:0], sh};
                                        idx <= idx + 9'h001;
                                        if (last) st <= HCSP_E_STOP;
                                    end else if (step == 2'h1) begin
                                        step <= 2'h2;
                                        st <= HCSP_E_START; // repeated
                                        o_drv.scl_oe <= 1'b1;
                                    end else step <= step + 2'h1;
                                end
                            end
                        endcase
                    end
                    HCSP_E_STOP: begin
                        // sda low, scl released, then sda released
                        if (ph == 2'h0) o_drv.sda_oe <= 1'b1;
                        if (ph == 2'h1) o_drv.scl_oe <= 1'b0;
                        if (ph == 2'h3) begin
                            o_drv.sda_oe <= 1'b0;
                            st <= HCSP_E_DONE;
                        end
                    end
                    HCSP_E_DONE: o_done <= 1'b1;
                    default: st <= HCSP_E_IDLE;
                endcase
            end
            // repeated start needs sda released before the clock rises
            if (tick && st == HCSP_E_START && ph == 2'h0 && step == 2'h2)
                o_drv <= '{1'b1, 1'b0};
            if (tick && st == HCSP_E_START && ph == 2'h1 && step == 2'h2)
                o_drv <= '{1'b0, 1'b0};
            if (tick && st == HCSP_E_START && ph == 2'h2 && step == 2'h2)
                o_drv <= '{1'b0, 1'b1};
        end
    end
endmodule

// File: hcsp_smb_target.sv
// smbus block read/write target front end
`timescale 1ns/100ps
`include "hcsp_defs.svh"
module hcsp_smb_target (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_en,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic [7:0] i_rdata,
    output logic [7:0] o_raddr,
    output hcsp_pkg::hcsp_wr_t o_wr,
    output logic o_sda_oe,
    output logic o_acked
);
    typedef enum logic [2:0] {
        HCSP_S_IDLE = 3'h0,
        HCSP_S_ADDR = 3'h1,
        HCSP_S_CMD = 3'h2,
        HCSP_S_CNT = 3'h3,
        HCSP_S_WDAT = 3'h4,
        HCSP_S_RCNT = 3'h5,
        HCSP_S_RDAT = 3'h6,
        HCSP_S_SKIP = 3'h7
    } hcsp_s_st_t;
    hcsp_s_st_t st; // transaction state
    logic scl_d, sda_d; // previous samples
    logic [3:0] bitn; // bit count, 8 = ack slot
    logic [7:0] sh; // receive shift
    logic [7:0] cmd; // register address
    logic [7:0] cnt; // bytes remaining
    logic [7:0] txb; // byte being sent
    logic rd_dir; // current byte flows to host
    logic nack; // host declined more read data
    logic any_bit; // a bit was seen since start
    logic [20:0] low_cnt; // clock-low timer
    logic [7:0] buf_d [0:31]; // write data held until stop
    logic [7:0] buf_a; // first register of a held write
    logic [5:0] buf_n; // bytes held
    logic buf_ok; // held write is complete and valid
    logic [5:0] cp_i; // commit index
    logic committing; // copying held bytes to registers
    wire scl_rise = i_scl & ~scl_d;
    wire scl_fall = ~i_scl & scl_d;
    wire start_c = i_scl & scl_d & sda_d & ~i_sda;
    wire stop_c = i_scl & scl_d & ~sda_d & i_sda;
    wire tout = (low_cnt == 21'(`HCSP_TOUT_CYC));
    wire [7:0] byte_in = {sh[6:0], i_sda};
    // byte decisions at the last clock fall look at the full shift register
    wire addr_ok = (sh[7:1] == `HCSP_SMB_ADDR);
    wire reg_ok = (sh <= `HCSP_LAST_REG) |
                  (sh == `HCSP_REG_STAT);
    wire cnt_ok = (sh != 8'h00) &
                  (sh <= `HCSP_MAX_CNT);
    assign o_raddr = cmd;
    // clock-low timer
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) low_cnt <= 21'h000000;
        else if (i_scl | tout) low_cnt <= 21'h000000;
        else low_cnt <= low_cnt + 21'h000001;
    end
    // receive and answer, never touching the clock
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= HCSP_S_IDLE;
            {scl_d, sda_d} <= 2'h3;
            bitn <= 4'h0;
            sh <= 8'h00;
            cmd <= 8'h00;
            cnt <= 8'h00;
            txb <= 8'h00;
            rd_dir <= 1'b0;
            nack <= 1'b0;
            any_bit <= 1'b0;
            buf_a <= 8'h00;
            buf_n <= 6'h00;
            buf_ok <= 1'b0;
            cp_i <= 6'h00;
            committing <= 1'b0;
            o_sda_oe <= 1'b0;
            o_acked <= 1'b0;
            o_wr <= '0;
        end else begin
            scl_d <= i_scl;
            sda_d <= i_sda;
            o_wr.we <= 1'b0;
            o_acked <= 1'b0;
            // copy a finished block write into registers
            if (committing) begin
                o_wr <= '{1'b1, 8'(buf_a + {2'h0, cp_i}), buf_d[cp_i[4:0]]};
                cp_i <= cp_i + 6'h01;
                if (cp_i + 6'h01 == buf_n) committing <= 1'b0;
            end
            if (!i_en || tout) begin
                st <= HCSP_S_IDLE;
                o_sda_oe <= 1'b0;
                buf_ok <= 1'b0;
            end else if (start_c) begin
                st <= HCSP_S_ADDR;
                // the start's own clock fall wraps this to bit 0
                bitn <= 4'hF;
                any_bit <= 1'b0;
                rd_dir <= 1'b0;
                o_sda_oe <= 1'b0;
                buf_ok <= 1'b0;
            end else if (stop_c) begin
                // start then stop only resets
                if (buf_ok && any_bit) begin
                    committing <= 1'b1;
                    cp_i <= 6'h00;
                end
                buf_ok <= 1'b0;
                st <= HCSP_S_IDLE;
                o_sda_oe <= 1'b0;
            end else if (st != HCSP_S_IDLE && st != HCSP_S_SKIP) begin
                if (scl_rise) begin
                    any_bit <= 1'b1;
                    if (bitn != 4'h8) sh <= byte_in;
                    else if (rd_dir) nack <= i_sda;
                end
                if (scl_fall) begin
                    bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
                    o_sda_oe <= 1'b0;
                    if (bitn == 4'h7 && !rd_dir) begin
                        // byte received: decide ack or silence
                        o_sda_oe <= 1'b1;
                        case (st)
                            HCSP_S_ADDR: begin
                                if (!addr_ok) begin
                                    st <= HCSP_S_SKIP;
                                    o_sda_oe <= 1'b0;
                                end else if (sh[0]) begin
                                    if (cmd == `HCSP_REG_STAT &&
                                        st == HCSP_S_ADDR) begin
                                        txb <= 8'h01;
                                    end else txb <= `HCSP_MAX_CNT;
                                    cnt <= `HCSP_MAX_CNT;
                                    st <= HCSP_S_RCNT;
                                end else st <= HCSP_S_CMD;
                            end
                            HCSP_S_CMD: begin
                                cmd <= sh;
                                if (!reg_ok) begin
                                    st <= HCSP_S_SKIP;
                                    o_sda_oe <= 1'b0;
                                end else st <= HCSP_S_CNT;
                            end
                            HCSP_S_CNT: begin
                                if (!cnt_ok) begin
                                    st <= HCSP_S_SKIP;
                                    o_sda_oe <= 1'b0;
                                end else begin
                                    cnt <= sh;
                                    buf_a <= cmd;
                                    buf_n <= 6'h00;
                                    st <= HCSP_S_WDAT;
                                end
                            end
                            HCSP_S_WDAT: begin
                                buf_d[buf_n[4:0]] <= sh;
                                buf_n <= buf_n + 6'h01;
                                cnt <= cnt - 8'h01;
                                if (cnt == 8'h01) begin
                                    buf_ok <= 1'b1;
                                    st <= HCSP_S_SKIP;
                                end
                            end
                            default: st <= HCSP_S_SKIP;
                        endcase
                    end else if (bitn == 4'h8 && st == HCSP_S_RCNT) begin
                        // after address ack, drive the count byte
                        rd_dir <= 1'b1;
                        o_acked <= 1'b1;
                        o_sda_oe <= ~txb[7];
                        st <= HCSP_S_RDAT;
                        txb <= {txb[6:0], 1'b0};
                    end else if (rd_dir && bitn < 4'h7) begin
                        o_sda_oe <= ~txb[7];
                        txb <= {txb[6:0], 1'b0};
                    end else if (rd_dir && bitn == 4'h8) begin
                        // next data byte from the register file
                        if (nack || cnt == 8'h00) st <= HCSP_S_SKIP;
                        else begin
                            o_sda_oe <= ~i_rdata[7];
                            txb <= {i_rdata[6:0], 1'b0};
                            cmd <= cmd + 8'h01;
                            cnt <= cnt - 8'h01;
                        end
                    end
                end
            end else if (scl_fall) begin
                // release an ack given just before skipping
                o_sda_oe <= 1'b0;
            end
        end
    end
endmodule

// File: hcsp_top.sv
// hub configuration serial port: eeprom loader or smbus target
`timescale 1ns/100ps
`include "hcsp_defs.svh"
module hcsp_top (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_config_select_hi,
    input wire logic i_config_select_lo,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_scl_oe,
    output logic o_sda,
    output logic o_sda_oe,
    output logic o_usb_attach,
    output logic o_iface_power_down
);
    logic smb_mode; // strap caught after reset
    logic strap_done; // straps taken
    logic [7:0] mem [0:255]; // register set
    logic [7:0] config_status_command; // status/command
    logic soft_rst; // register reset request
    logic ee_go; // start eeprom load
    hcsp_pkg::hcsp_drv_t ee_drv;
    hcsp_pkg::hcsp_wr_t ee_wr, sm_wr;
    logic ee_done;
    logic sm_oe, sm_acked;
    logic [7:0] raddr;
    logic pdn_pend; // power down waits for ack end
    logic [255:0] mem_ok; // entry written since the last reset
    wire smb_strap = i_config_select_hi & ~i_config_select_lo;
    wire sm_en = smb_mode & strap_done & ~o_iface_power_down;
    wire [7:0] rdata = (raddr == `HCSP_REG_STAT) ? config_status_command :
                       mem_ok[raddr] ? mem[raddr] : `HCSP_MEM_RST;
    // writes to 00h-FEh blocked once attached
    wire mem_we = sm_wr.we & ~config_status_command[`HCSP_BIT_ATT] &
                  (sm_wr.addr != `HCSP_REG_STAT);
    wire stat_we = sm_wr.we & (sm_wr.addr == `HCSP_REG_STAT);
    // strap capture at release; eeprom start only in eeprom mode
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            smb_mode <= 1'b0;
            strap_done <= 1'b0;
            ee_go <= 1'b0;
        end else if (!strap_done) begin
            smb_mode <= smb_strap;
            strap_done <= 1'b1;
            ee_go <= ~smb_strap;
        end
    end
    hcsp_ee_master u_ee (
        .i_clk(i_clk),
        .i_rst(i_rst | smb_mode),
        .i_start(ee_go),
        .i_sda(i_sda),
        .o_drv(ee_drv),
        .o_wr(ee_wr),
        .o_done(ee_done)
    );
    hcsp_smb_target u_smb (
        .i_clk(i_clk),
        .i_rst(i_rst | soft_rst),
        .i_en(sm_en),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .i_rdata(rdata),
        .o_raddr(raddr),
        .o_wr(sm_wr),
        .o_sda_oe(sm_oe),
        .o_acked(sm_acked)
    );
    // register array, filled by eeprom or host
    always_ff @(posedge i_clk) begin
        if (ee_wr.we) mem[ee_wr.addr] <= ee_wr.data;
        else if (mem_we) mem[sm_wr.addr] <= sm_wr.data;
    end
    // written flags: both resets make every entry read back as default
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) mem_ok <= '0;
        else if (soft_rst) mem_ok <= '0;
        else if (ee_wr.we) mem_ok[ee_wr.addr] <= 1'b1;
        else if (mem_we) mem_ok[sm_wr.addr] <= 1'b1;
    end
    // status/command register and its side effects
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            config_status_command <= `HCSP_MEM_RST;
            soft_rst <= 1'b0;
            pdn_pend <= 1'b0;
        end else begin
            soft_rst <= 1'b0;
            if (soft_rst) config_status_command <= `HCSP_MEM_RST;
            else if (stat_we) begin
                config_status_command <= sm_wr.data & `HCSP_STAT_MASK;
                soft_rst <= sm_wr.data[`HCSP_BIT_RST];
                pdn_pend <= sm_wr.data[`HCSP_BIT_PDN];
            end
            if (pdn_pend && !sm_oe) pdn_pend <= 1'b0;
        end
    end
    // outputs; attach only after load completes, no time limit
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_scl <= 1'b0;
            o_scl_oe <= 1'b0;
            o_sda <= 1'b0;
            o_sda_oe <= 1'b0;
            o_usb_attach <= 1'b0;
            o_iface_power_down <= 1'b0;
        end else begin
            o_scl_oe <= ~smb_mode & ee_drv.scl_oe;
            o_sda_oe <= smb_mode ? sm_oe : ee_drv.sda_oe;
            o_usb_attach <= smb_mode ?
                config_status_command[`HCSP_BIT_ATT] : ee_done;
            if (soft_rst) o_iface_power_down <= 1'b0;
            else if (pdn_pend && !sm_oe)
                o_iface_power_down <= 1'b1;
        end
    end
endmodule

// File: hcsp_bus_model.sv
// open-drain bus with pull-ups and an acknowledging serial eeprom
`timescale 1ns/100ps
module hcsp_bus_model (
    input wire logic i_clk,
    input wire logic i_host_scl,
    input wire logic i_host_sda,
    input wire logic i_dut_scl_oe,
    input wire logic i_dut_sda_oe,
    input wire logic i_ee_on,
    output logic o_scl,
    output logic o_sda
);
    logic ack_low = 1'b0; // eeprom pulls sda low to acknowledge
    logic [3:0] bits = 4'h0; // clock falls since the last start or ack, stops at 8
    logic scl_d = 1'b1; // line levels one clock ago
    logic sda_d = 1'b1;
    // pull-ups win unless some party pulls the line low
    assign o_scl = i_host_scl & ~i_dut_scl_oe;
    assign o_sda = i_host_sda & ~i_dut_sda_oe & ~ack_low;
    // eeprom acks the ninth bit of every byte, absent in smbus mode
    always @(posedge i_clk) begin
        scl_d <= o_scl;
        sda_d <= o_sda;
        if (!i_ee_on) begin
            ack_low <= 1'b0;
        end else if (o_scl && sda_d && !o_sda) begin
            bits <= 4'h0; // start or repeated start
        end else if (scl_d && !o_scl) begin
            if (ack_low) begin
                ack_low <= 1'b0; // release after the ack clock
                bits <= 4'h1;
            end else if (bits == 4'h8) begin
                ack_low <= 1'b1; // byte done
            end else begin
                bits <= bits + 4'h1;
            end
        end
    end
endmodule

// File: hcsp_checker_assertions.sv
// assertions on the ports of the configuration serial port
`timescale 1ns/100ps
module hcsp_top_checker (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_config_select_hi,
    input wire logic i_config_select_lo,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_scl,
    input wire logic o_scl_oe,
    input wire logic o_sda,
    input wire logic o_sda_oe,
    input wire logic o_usb_attach,
    input wire logic o_iface_power_down
);
    wire smb; // smbus strap selected
    assign smb = i_config_select_hi & ~i_config_select_lo;
    default clocking @(posedge i_clk); endclocking
    property p_rst_off; i_rst |-> !o_scl_oe && !o_sda_oe; endproperty
    a_rst_off: assert property (p_rst_off)
        else $error("pin in reset");
    property p_smb_scl; disable iff (i_rst) smb |-> !o_scl_oe; endproperty
    a_smb_scl: assert property (p_smb_scl)
        else $error("scl held");
    property p_sda_on;
        disable iff (i_rst) smb && $rose(o_sda_oe) |-> !i_scl;
    endproperty
    a_sda_on: assert property (p_sda_on)
        else $error("sda on");
    property p_sda_off;
        disable iff (i_rst) smb && $fell(o_sda_oe) |-> !i_scl;
    endproperty
    a_sda_off: assert property (p_sda_off)
        else $error("sda off");
    property p_pdn_quiet;
        disable iff (i_rst) o_iface_power_down |-> !o_sda_oe;
    endproperty
    a_pdn_quiet: assert property (p_pdn_quiet)
        else $error("pdn ack");
    property p_pdn_hold;
        disable iff (i_rst) o_iface_power_down |=> o_iface_power_down;
    endproperty
    a_pdn_hold: assert property (p_pdn_hold)
        else $error("pdn lost");
    property p_att_idle;
        disable iff (i_rst) smb && $rose(o_usb_attach) |-> i_scl && i_sda;
    endproperty
    a_att_idle: assert property (p_att_idle)
        else $error("att");
    property p_ee_high;
        disable iff (i_rst) !smb && $fell(o_scl_oe) |=> (!o_scl_oe) [*8];
    endproperty
    a_ee_high: assert property (p_ee_high)
        else $error("fast scl");
endmodule
bind hcsp_top hcsp_top_checker chk_u (
    .i_clk(i_clk), .i_rst(i_rst),
    .i_config_select_hi(i_config_select_hi),
    .i_config_select_lo(i_config_select_lo),
    .i_scl(i_scl), .i_sda(i_sda), .o_scl(o_scl), .o_scl_oe(o_scl_oe),
    .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_usb_attach(o_usb_attach),
    .o_iface_power_down(o_iface_power_down)
);

// File: hub_config_serial_port_bench.sv
// self-checking bench for the hub configuration serial port
`timescale 1ns/100ps
module hub_config_serial_port_bench;
    localparam int Q = 25; // quarter of an smbus bit in clocks
    logic clk = 1'b0; // 40 MHz clock
    logic rst = 1'b1; // active high reset
    logic sel_hi = 1'b0; // mode straps, eeprom first
    logic sel_lo = 1'b0;
    logic h_scl = 1'b1; // host pulls, 1 releases the line
    logic h_sda = 1'b1;
    wire scl_w, sda_w, scl_oe, sda_oe, attach, pdn, scl_o, sda_o;
    int errors = 0;
    int checked = 0;
    always #12.5 clk = ~clk;
    hcsp_top dut_u (
        .i_clk(clk), .i_rst(rst), .i_config_select_hi(sel_hi),
        .i_config_select_lo(sel_lo), .i_scl(scl_w), .i_sda(sda_w),
        .o_scl(scl_o), .o_scl_oe(scl_oe), .o_sda(sda_o), .o_sda_oe(sda_oe),
        .o_usb_attach(attach), .o_iface_power_down(pdn)
    );
    hcsp_bus_model bus_u (
        .i_clk(clk), .i_host_scl(h_scl), .i_host_sda(h_sda),
        .i_dut_scl_oe(scl_oe), .i_dut_sda_oe(sda_oe),
        .i_ee_on(!(sel_hi && !sel_lo)), .o_scl(scl_w), .o_sda(sda_w)
    );
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, want, input string s);
        checked++;
        if (got !== want) begin
            errors++;
            $display("[ERR] %0t %s got %h want %h", $time, s, got, want);
        end
    endtask
    // wait for the resolved clock line, bounded
    task automatic wait_scl(input logic v);
        int n;
        n = 0;
        while (scl_w !== v && n < 2000) begin
            tick(1);
            n++;
        end
        if (n == 2000) begin
            errors++;
            $display("[ERR] %0t clock line stuck", $time);
            wrap_up();
        end
    endtask
    // start (s=1) or stop (s=0) condition, msb-first bytes follow
    task automatic cond(input logic s);
        h_sda <= s;
        tick(Q);
        h_scl <= 1'b1;
        tick(Q);
        h_sda <= !s;
        tick(Q);
        h_scl <= !s;
        tick(Q);
    endtask
    // one byte plus ninth bit h9; r collects sda, k is the ack seen
    task automatic xfer(input logic [7:0] d, input logic h9,
                        output logic [7:0] r, output logic k);
        for (int i = 8; i >= 0; i--) begin
            h_sda <= (i == 0) ? h9 : d[i-1];
            tick(Q);
            h_scl <= 1'b1;
            tick(Q);
            if (i > 0) r[i-1] = sda_w;
            k = !sda_w;
            tick(Q);
            h_scl <= 1'b0;
            tick(Q);
        end
    endtask
    // block write of one data byte d to register c with byte count n
    task automatic blk_wr(input logic [6:0] a, input logic [7:0] c, n, d,
                          input logic want, input string s);
        logic [7:0] r;
        logic k;
        cond(1'b1);
        xfer({a, 1'b0}, 1'b1, r, k);
        check({7'h00, k}, {7'h00, want}, "address ack");
        if (k) begin
            xfer(c, 1'b1, r, k);
            xfer(n, 1'b1, r, k);
            check({7'h00, k}, {7'h00, n != 8'h00}, "count ack");
            if (k) xfer(d, 1'b1, r, k);
        end
        cond(1'b0);
        tick(Q);
        $display("test %s done", s);
    endtask
    // block read from register c: count n, one data byte d, then nack
    task automatic blk_rd(input logic [7:0] c, output logic [7:0] n, d);
        logic k;
        cond(1'b1);
        xfer(8'h58, 1'b1, d, k);
        xfer(c, 1'b1, d, k);
        cond(1'b1);
        xfer(8'h59, 1'b1, d, k);
        xfer(8'hFF, 1'b0, n, k);
        xfer(8'hFF, 1'b1, d, k);
        cond(1'b0);
        tick(Q);
    endtask
    initial begin
        logic [7:0] b;
        logic [7:0] v;
        tick(5);
        check({6'h00, scl_oe, sda_oe}, 8'h00, "reset");
        rst <= 1'b0;
        wait_scl(1'b0);
        check({7'h00, sda_w}, 8'h00, "start");
        for (int i = 7; i >= 0; i--) begin
            wait_scl(1'b1);
            b[i] = sda_w;
            wait_scl(1'b0);
        end
        check(b, 8'hA0, "eeprom address");
        $display("test eeprom address done");
        rst <= 1'b1;
        sel_hi <= 1'b1;
        tick(5);
        rst <= 1'b0;
        tick(10);
        blk_wr(7'h2D, 8'hFF, 8'h01, 8'h01, 1'b0, "bad address");
        blk_wr(7'h00, 8'hFF, 8'h01, 8'h01, 1'b0, "general call");
        blk_wr(7'h2C, 8'hFF, 8'h00, 8'h01, 1'b1, "zero count");
        check({7'h00, attach}, 8'h00, "no attach");
        blk_wr(7'h2C, 8'h00, 8'h01, 8'h5A, 1'b1, "load");
        blk_wr(7'h2C, 8'hFF, 8'h01, 8'h01, 1'b1, "attach");
        check({7'h00, attach}, 8'h01, "attach");
        blk_wr(7'h2C, 8'h00, 8'h01, 8'hA5, 1'b1, "protect");
        blk_rd(8'hFF, b, v);
        check(b, 8'h01, "read count");
        check(v, 8'h01, "read status");
        blk_rd(8'h00, b, v);
        check(b, 8'h20, "full count");
        check(v, 8'h5A, "protected");
        $display("test read back done");
        blk_wr(7'h2C, 8'hFF, 8'h01, 8'h03, 1'b1, "soft reset");
        check({7'h00, attach}, 8'h00, "detach");
        blk_rd(8'h00, b, v);
        check(v, 8'h00, "cleared");
        blk_wr(7'h2C, 8'hFF, 8'h01, 8'h04, 1'b1, "power down");
        check({7'h00, pdn}, 8'h01, "power down");
        blk_wr(7'h2C, 8'hFF, 8'h01, 8'h01, 1'b0, "asleep");
        check({6'h00, scl_o, sda_o}, 8'h00, "open drain");
        wrap_up();
    end
endmodule
